// ### common/dwu_pkg.sv
package dwu_pkg;
    // Number of watchpoints and the logical cores one control word can arm.
    localparam int DWU_NUM_WATCH = 4;
    localparam int DWU_NUM_CORES = 8;
    // Resource identifier layout of a processor-status operation.
    localparam int DWU_PS_SHIFT = 8;
    localparam logic [7:0] DWU_PS_TYPE = 8'h0C;
    // Register numbers of the first watchpoint in each bank.
    localparam logic [7:0] DWU_LOW_BASE = 8'h50;
    localparam logic [7:0] DWU_HIGH_BASE = 8'h60;
    localparam logic [7:0] DWU_CTRL_BASE = 8'h70;
    // Control word fields.
    localparam int DWU_CTRL_EN_BIT = 0;
    localparam int DWU_CTRL_OUT_BIT = 1;
    localparam int DWU_CTRL_LOAD_BIT = 2;
    localparam int DWU_CTRL_CORE_LSB = 16;
    localparam int DWU_CTRL_CORE_W = 8;
    localparam logic [31:0] DWU_CTRL_WMASK = 32'h00FF0007;
    // Values after reset.
    localparam logic [31:0] DWU_CTRL_RST = 32'h00000000;
    localparam logic [31:0] DWU_BOUND_RST = 32'h00000000;
    localparam logic [31:0] DWU_RDATA_RST = 32'h00000000;
    // Register bank selected by a processor-status number.
    typedef enum logic [1:0] {
        DWU_BANK_NONE = 2'b00,
        DWU_BANK_LOW = 2'b01,
        DWU_BANK_HIGH = 2'b10,
        DWU_BANK_CTRL = 2'b11
    } dwu_bank_e;
endpackage

// ### rtl/dwu_watch.sv
`timescale 1ns/1ps
`default_nettype none
module dwu_watch
    import dwu_pkg::*;
#(
    parameter int NUM_CORES = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wr_low,
    input wire logic wr_high,
    input wire logic wr_ctrl,
    input wire logic [31:0] wdata,
    input wire logic [31:0] acc_addr,
    input wire logic acc_store,
    input wire logic [$clog2(NUM_CORES)-1:0] acc_core,
    output logic [31:0] low_q,
    output logic [31:0] high_q,
    output logic [31:0] ctrl_q,
    output logic hit
);
    logic [31:0] low_d;
    logic [31:0] high_d;
    logic [31:0] ctrl_d;
    logic [DWU_CTRL_CORE_W-1:0] core_en;
    logic in_incl;
    logic in_open;
    logic range_hit;

    // The core enable field has eight bits, and one core needs no index.
    if (NUM_CORES < 2 || NUM_CORES > DWU_CTRL_CORE_W) begin : g_bad_cores
        $error("NUM_CORES must lie between 2 and 8");
    end

    // Next values of the two bounds and the control word.
    always_comb begin
        low_d = wr_low ? wdata : low_q;
        high_d = wr_high ? wdata : high_q;
        ctrl_d = wr_ctrl ? (wdata & DWU_CTRL_WMASK) : ctrl_q;
    end

    // Reserved control bits never store, so they always read as zero.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_q <= DWU_BOUND_RST;
            high_q <= DWU_BOUND_RST;
            ctrl_q <= DWU_CTRL_RST;
        end else begin
            low_q <= low_d;
            high_q <= high_d;
            ctrl_q <= ctrl_d;
        end
    end

    // Address match against the selected range mode, then the arming gates.
    always_comb begin
        core_en = ctrl_q[DWU_CTRL_CORE_LSB +: DWU_CTRL_CORE_W];
        in_incl = (acc_addr >= low_q) && (acc_addr <= high_q);
        in_open = (acc_addr > high_q) && (acc_addr < low_q);
        range_hit = ctrl_q[DWU_CTRL_OUT_BIT] ? !in_open : in_incl;
        hit = ctrl_q[DWU_CTRL_EN_BIT]
            && core_en[acc_core]
            && (acc_store || ctrl_q[DWU_CTRL_LOAD_BIT])
            && range_hit;
    end
endmodule
`default_nettype wire

// ### rtl/dwu_top.sv
// Operation
// - Four 32-bit first-bound registers at 0x50-0x53.
// - Four 32-bit second-bound registers at 0x60-0x63.
// - Control registers 0x70-0x73, reserved bits read-only.
// - Bits 23:16 arm each logical core; reset zero.
// - Bit 2 lets loads trigger; reset zero.
// - Stores always trigger an armed watchpoint.
// - Bit 1 clear: inclusive range first to second.
// - Bit 1 set: outside open range second-first.
// - Bit 0 is master enable, reset zero.
// - Core reads registers via status operations; writes only in debug mode.
`timescale 1ns/1ps
`default_nettype none
module dwu_top
    import dwu_pkg::*;
#(
    parameter int NUM_CORES = DWU_NUM_CORES
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ps_req,
    input wire logic ps_write,
    input wire logic [15:0] ps_resource,
    input wire logic [31:0] ps_wdata,
    input wire logic dbg_mode,
    input wire logic acc_valid,
    input wire logic acc_store,
    input wire logic [$clog2(NUM_CORES)-1:0] acc_core,
    input wire logic [31:0] acc_addr,
    output logic ps_ack,
    output logic ps_err,
    output logic [31:0] ps_rdata,
    output logic wp_event,
    output logic [DWU_NUM_WATCH-1:0] wp_hit,
    output logic [1:0] wp_id,
    output logic [$clog2(NUM_CORES)-1:0] wp_core,
    output logic [31:0] wp_addr
);
    localparam int CW = $clog2(NUM_CORES);

    // The core enable field has eight bits, and one core needs no index.
    if (NUM_CORES < 2 || NUM_CORES > DWU_CTRL_CORE_W) begin : g_bad_cores
        $error("NUM_CORES must lie between 2 and 8");
    end

    logic rst_meta_q;
    logic rst_sync_q;
    logic rst_n;

    // The release is synchronised so that every flop leaves reset on one edge.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    assign rst_n = rst_sync_q;

    logic [7:0] ps_num;
    logic type_ok;
    logic [1:0] ps_idx;
    dwu_bank_e bank;
    logic wr_ok;
    logic [DWU_NUM_WATCH-1:0] wr_low;
    logic [DWU_NUM_WATCH-1:0] wr_high;
    logic [DWU_NUM_WATCH-1:0] wr_ctrl;
    logic [31:0] low_v [DWU_NUM_WATCH];
    logic [31:0] high_v [DWU_NUM_WATCH];
    logic [31:0] ctrl_v [DWU_NUM_WATCH];
    logic [DWU_NUM_WATCH-1:0] hit_v;

    // Decode the resource identifier into a bank and a watchpoint index.
    always_comb begin
        ps_num = ps_resource[DWU_PS_SHIFT +: 8];
        type_ok = (ps_resource[7:0] == DWU_PS_TYPE);
        ps_idx = ps_num[1:0];
        if (!type_ok) begin
            bank = DWU_BANK_NONE;
        end else if (ps_num[7:2] == DWU_LOW_BASE[7:2]) begin
            bank = DWU_BANK_LOW;
        end else if (ps_num[7:2] == DWU_HIGH_BASE[7:2]) begin
            bank = DWU_BANK_HIGH;
        end else if (ps_num[7:2] == DWU_CTRL_BASE[7:2]) begin
            bank = DWU_BANK_CTRL;
        end else begin
            bank = DWU_BANK_NONE;
        end
        // Debug registers only accept writes while the tile is in debug mode.
        wr_ok = ps_req && ps_write && dbg_mode && (bank != DWU_BANK_NONE);
        for (int i = 0; i < DWU_NUM_WATCH; i++) begin
            wr_low[i] = wr_ok && (bank == DWU_BANK_LOW) && (ps_idx == i[1:0]);
            wr_high[i] = wr_ok && (bank == DWU_BANK_HIGH) && (ps_idx == i[1:0]);
            wr_ctrl[i] = wr_ok && (bank == DWU_BANK_CTRL) && (ps_idx == i[1:0]);
        end
    end

    // One comparator and register set per watchpoint.
    for (genvar g = 0; g < DWU_NUM_WATCH; g++) begin : g_watch
        dwu_watch #(
            .NUM_CORES(NUM_CORES)
        ) u_watch (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .wr_low(wr_low[g]),
            .wr_high(wr_high[g]),
            .wr_ctrl(wr_ctrl[g]),
            .wdata(ps_wdata),
            .acc_addr(acc_addr),
            .acc_store(acc_store),
            .acc_core(acc_core),
            .low_q(low_v[g]),
            .high_q(high_v[g]),
            .ctrl_q(ctrl_v[g]),
            .hit(hit_v[g])
        );
    end

    logic ps_ack_d;
    logic ps_err_d;
    logic [31:0] ps_rdata_d;

    // Answer every operation one cycle later; unmapped or refused ones flag an error.
    always_comb begin
        ps_ack_d = ps_req;
        ps_err_d = ps_req && ((bank == DWU_BANK_NONE) || (ps_write && !dbg_mode));
        ps_rdata_d = DWU_RDATA_RST;
        if (ps_req && !ps_write) begin
            case (bank)
                DWU_BANK_LOW: ps_rdata_d = low_v[ps_idx];
                DWU_BANK_HIGH: ps_rdata_d = high_v[ps_idx];
                DWU_BANK_CTRL: ps_rdata_d = ctrl_v[ps_idx];
                default: ps_rdata_d = DWU_RDATA_RST;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ps_ack <= 1'b0;
            ps_err <= 1'b0;
            ps_rdata <= DWU_RDATA_RST;
        end else begin
            ps_ack <= ps_ack_d;
            ps_err <= ps_err_d;
            ps_rdata <= ps_rdata_d;
        end
    end

    logic wp_event_d;
    logic [DWU_NUM_WATCH-1:0] wp_hit_d;
    logic [1:0] wp_id_d;
    logic [CW-1:0] wp_core_d;
    logic [31:0] wp_addr_d;

    // Lowest numbered watchpoint names the event when several match at once.
    always_comb begin
        wp_hit_d = acc_valid ? hit_v : '0;
        wp_event_d = |wp_hit_d;
        wp_id_d = wp_id;
        wp_core_d = wp_core;
        wp_addr_d = wp_addr;
        for (int i = DWU_NUM_WATCH - 1; i >= 0; i--) begin
            if (wp_hit_d[i]) begin
                wp_id_d = i[1:0];
            end
        end
        if (wp_event_d) begin
            wp_core_d = acc_core;
            wp_addr_d = acc_addr;
        end
    end

    // Identity and address hold after the pulse until the next event.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_event <= 1'b0;
            wp_hit <= '0;
            wp_id <= 2'h0;
            wp_core <= '0;
            wp_addr <= DWU_BOUND_RST;
        end else begin
            wp_event <= wp_event_d;
            wp_hit <= wp_hit_d;
            wp_id <= wp_id_d;
            wp_core <= wp_core_d;
            wp_addr <= wp_addr_d;
        end
    end

    // Helper terms: arming of watchpoint 0, and enable and load bits of all four, recomputed independently of the comparator.
    logic w0_armed;
    logic [DWU_NUM_WATCH-1:0] en_all;
    logic [DWU_NUM_WATCH-1:0] load_all;
    always_comb begin
        w0_armed = ctrl_v[0][0] && ctrl_v[0][16 + 32'(acc_core)];
        for (int i = 0; i < DWU_NUM_WATCH; i++) begin
            en_all[i] = ctrl_v[i][0];
            load_all[i] = ctrl_v[i][2];
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_PS_ACK: assert property (ps_req && !ps_write
        && ps_resource == 16'h700C |=> ps_ack && !ps_err)
        else $error("status operation not answered");
    AST_NO_ACK: assert property (!ps_req |=> !ps_ack)
        else $error("answer without a request");
    AST_LOW_WRITE: assert property (ps_req && ps_write && dbg_mode
        && ps_resource == 16'h500C |=> low_v[0] == $past(ps_wdata))
        else $error("first bound write lost");
    AST_HIGH_READ: assert property (ps_req && !ps_write
        && ps_resource == 16'h630C |=> ps_rdata == $past(high_v[3]) && !ps_err)
        else $error("second bound read wrong");
    AST_CTRL_RSVD: assert property ((ctrl_v[1] & ~DWU_CTRL_WMASK) == 32'h00000000)
        else $error("reserved control bits set");
    AST_CORE_OFF: assert property (acc_valid && !ctrl_v[0][16 + 32'(acc_core)]
        |=> !wp_hit[0])
        else $error("unarmed core triggered");
    AST_LOAD_GATE: assert property (acc_valid && !acc_store && load_all == '0
        |=> !wp_event)
        else $error("load triggered without load enable");
    AST_INCL: assert property (acc_valid && acc_store && w0_armed && !ctrl_v[0][1]
        && acc_addr >= low_v[0] && acc_addr <= high_v[0]
        |=> wp_event && wp_hit[0] && wp_id == 2'h0)
        else $error("inclusive store hit missed");
    AST_EXCL: assert property (acc_valid && ctrl_v[0][1]
        && acc_addr > high_v[0] && acc_addr < low_v[0] |=> !wp_hit[0])
        else $error("exclusive mode hit inside open range");
    AST_MASTER: assert property (acc_valid && en_all == '0 |=> !wp_event)
        else $error("trigger while disabled");

    COV_WRITE_CTRL: cover property (ps_req && ps_write && bank == DWU_BANK_CTRL ##1 ps_ack);
    COV_STORE_HIT: cover property (acc_valid && acc_store ##1 wp_event);
    COV_LOAD_HIT: cover property (acc_valid && !acc_store ##1 wp_event);
    COV_EXCL_HIT: cover property (acc_valid && ctrl_v[0][1] ##1 wp_hit[0]);
endmodule
`default_nettype wire

// ### verification/dwu_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural processor core that issues status operations and data accesses.
module dwu_core_model
    import dwu_pkg::*;
(
    input wire logic sys_clk,
    input wire logic ps_err,
    input wire logic [31:0] ps_rdata,
    output logic ps_req,
    output logic ps_write,
    output logic [15:0] ps_resource,
    output logic [31:0] ps_wdata,
    output logic dbg_mode,
    output logic acc_valid,
    output logic acc_store,
    output logic [2:0] acc_core,
    output logic [31:0] acc_addr
);
    // Idle lines carry inverted data so a stale value never looks live.
    initial begin
        ps_req = 1'b0;
        ps_write = 1'b0;
        ps_resource = 16'hFFFF;
        ps_wdata = 32'hFFFFFFFF;
        dbg_mode = 1'b1;
        acc_valid = 1'b0;
        acc_store = 1'b0;
        acc_core = 3'h0;
        acc_addr = 32'hFFFFFFFF;
    end
    // One request cycle only, since every high cycle counts as a new operation.
    task automatic ps_op(input logic wr, input logic [7:0] num, input logic [7:0] low,
        input logic [31:0] wd, output logic err, output logic [31:0] rd);
        @(posedge sys_clk);
        #1;
        ps_req = 1'b1;
        ps_write = wr;
        ps_resource = {num, low};
        ps_wdata = wd;
        @(posedge sys_clk);
        #1;
        ps_req = 1'b0;
        ps_resource = ~ps_resource;
        ps_wdata = ~wd;
        // The answer stands for this one cycle only, so it is taken now.
        err = ps_err;
        rd = ps_rdata;
    endtask
    // A single access; returns while the one-cycle answer still stands.
    task automatic acc(input logic st, input logic [2:0] core, input logic [31:0] addr);
        @(posedge sys_clk);
        #1;
        acc_valid = 1'b1;
        acc_store = st;
        acc_core = core;
        acc_addr = addr;
        @(posedge sys_clk);
        #1;
        acc_valid = 1'b0;
        acc_addr = ~addr;
    endtask
    // Debug mode changes between operations, never on a sampling edge.
    task automatic set_dbg(input logic v);
        dbg_mode = v;
    endtask
endmodule
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dwu_pkg::*;
    logic sys_clk, rstn, ps_req, ps_write, dbg_mode, acc_valid, acc_store;
    logic ps_ack, ps_err, wp_event, e;
    logic [15:0] ps_resource;
    logic [31:0] ps_wdata, acc_addr, ps_rdata, wp_addr, r;
    logic [2:0] acc_core, wp_core;
    logic [3:0] wp_hit;
    logic [1:0] wp_id;
    int fail_count = 0;
    int checks = 0;
    dwu_top dut (.sys_clk, .rstn, .ps_req, .ps_write, .ps_resource, .ps_wdata, .dbg_mode,
        .acc_valid, .acc_store, .acc_core, .acc_addr, .ps_ack, .ps_err, .ps_rdata,
        .wp_event, .wp_hit, .wp_id, .wp_core, .wp_addr);
    dwu_core_model u_core (.sys_clk, .ps_err, .ps_rdata, .ps_req, .ps_write, .ps_resource,
        .ps_wdata, .dbg_mode, .acc_valid, .acc_store, .acc_core, .acc_addr);
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic print_verdict();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] n, input logic [31:0] d);
        u_core.ps_op(1'b1, n, DWU_PS_TYPE, d, e, r);
        chk({30'h0, ps_ack, e}, 32'h2);
    endtask
    task automatic rd(input logic [7:0] n, input logic [31:0] x);
        u_core.ps_op(1'b0, n, DWU_PS_TYPE, 32'h0, e, r);
        chk({30'h0, ps_ack, e}, 32'h2);
        chk(r, x);
    endtask
    // The lowest set bit of the expected hit vector names the reported watchpoint.
    task automatic hit(input logic st, input logic [2:0] c, input logic [31:0] a,
        input logic [3:0] x);
        u_core.acc(st, c, a);
        chk({28'h0, wp_hit}, {28'h0, x});
        chk({31'h0, wp_event}, {31'h0, |x});
        if (x != 4'h0) begin
            chk({30'h0, wp_id}, x[0] ? 32'h0 : x[1] ? 32'h1 : x[2] ? 32'h2 : 32'h3);
            chk(wp_addr, a);
            chk({29'h0, wp_core}, {29'h0, c});
        end
    endtask
    task automatic t_reset();
        for (int i = 0; i < 4; i++) begin
            rd(DWU_LOW_BASE + 8'(i), 32'h0);
            rd(DWU_HIGH_BASE + 8'(i), 32'h0);
            rd(DWU_CTRL_BASE + 8'(i), 32'h0);
        end
    endtask
    task automatic t_regs();
        for (int i = 0; i < 4; i++) begin
            wr(DWU_LOW_BASE + 8'(i), 32'hA5000010 | i);
            wr(DWU_HIGH_BASE + 8'(i), 32'h5A0000F0 | i);
            wr(DWU_CTRL_BASE + 8'(i), 32'hFFFFFFFF);
            rd(DWU_LOW_BASE + 8'(i), 32'hA5000010 | i);
            rd(DWU_HIGH_BASE + 8'(i), 32'h5A0000F0 | i);
            rd(DWU_CTRL_BASE + 8'(i), 32'h00FF0007);
            wr(DWU_CTRL_BASE + 8'(i), 32'h0);
        end
    endtask
    // Unmapped numbers, a wrong type byte and ungated writes are all refused.
    task automatic t_refuse();
        u_core.ps_op(1'b1, 8'h54, DWU_PS_TYPE, 32'h1, e, r);
        chk({30'h0, ps_ack, e}, 32'h3);
        u_core.ps_op(1'b1, 8'h50, 8'h0D, 32'h1, e, r);
        chk({30'h0, ps_ack, e}, 32'h3);
        u_core.set_dbg(1'b0);
        u_core.ps_op(1'b1, 8'h50, DWU_PS_TYPE, 32'h1, e, r);
        chk({30'h0, ps_ack, e}, 32'h3);
        u_core.set_dbg(1'b1);
        rd(8'h50, 32'hA5000010);
    endtask
    task automatic t_match();
        wr(8'h50, 32'h100);
        wr(8'h60, 32'h200);
        wr(8'h70, 32'h00010001);
        hit(1'b1, 3'h0, 32'h100, 4'h1);
        hit(1'b1, 3'h0, 32'h200, 4'h1);
        hit(1'b1, 3'h0, 32'hFF, 4'h0);
        hit(1'b1, 3'h0, 32'h201, 4'h0);
        hit(1'b0, 3'h0, 32'h150, 4'h0);
        hit(1'b1, 3'h1, 32'h150, 4'h0);
        wr(8'h70, 32'h00010005);
        hit(1'b0, 3'h0, 32'h150, 4'h1);
        hit(1'b1, 3'h0, 32'h150, 4'h1);
        wr(8'h70, 32'h00010004);
        hit(1'b1, 3'h0, 32'h150, 4'h0);
        wr(8'h50, 32'h200);
        wr(8'h60, 32'h100);
        wr(8'h70, 32'h00010003);
        hit(1'b1, 3'h0, 32'h100, 4'h1);
        hit(1'b1, 3'h0, 32'h200, 4'h1);
        hit(1'b1, 3'h0, 32'h150, 4'h0);
        hit(1'b1, 3'h0, 32'h300, 4'h1);
    endtask
    // Two watchpoints armed for one core must both hit and report the lower one.
    task automatic t_multi();
        for (int i = 1; i < 3; i++) begin
            wr(DWU_LOW_BASE + 8'(i), 32'h0);
            wr(DWU_HIGH_BASE + 8'(i), 32'hFFFFFFFF);
            wr(DWU_CTRL_BASE + 8'(i), 32'h00020001);
        end
        hit(1'b1, 3'h1, 32'h150, 4'h6);
    endtask
    initial begin
        rstn = 1'b0;
        repeat (20) @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        repeat (3) @(posedge sys_clk);
        t_reset();
        t_regs();
        t_refuse();
        t_match();
        t_multi();
        print_verdict();
    end
    // Far beyond the fewer than two hundred cycles the sequence needs.
    initial begin
        #(3000 * 100);
        fail_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
